//--- common/fcpg_pkg.sv
// Package for the four-channel stepper pulse generator.
// Holds register map, field layouts, timing units and shared types.
package fcpg_pkg;
   // Channel count and register layout
   localparam int FCPG_NCH = 4;
   localparam logic [7:0] FCPG_CH_STRIDE = 8'h0_020;
   // Per-channel register word offsets (within a channel window)
   localparam logic [4:0] FCPG_OFF_COUNT = 5'h0_000;
   localparam logic [4:0] FCPG_OFF_RSTART = 5'h0_004;
   localparam logic [4:0] FCPG_OFF_RFINAL = 5'h0_008;
   localparam logic [4:0] FCPG_OFF_ACCEL = 5'h0_00C;
   localparam logic [4:0] FCPG_OFF_WIDTH = 5'h0_010;
   localparam logic [4:0] FCPG_OFF_CFG = 5'h0_014;
   localparam logic [4:0] FCPG_OFF_CTRL = 5'h0_018;
   localparam logic [4:0] FCPG_OFF_REMAIN = 5'h0_01C;
   // Global registers
   localparam logic [7:0] FCPG_ADDR_STATUS = 8'h0_080;
   localparam logic [7:0] FCPG_ADDR_MASK = 8'h0_084;
   localparam logic [7:0] FCPG_ADDR_IEN = 8'h0_088;
   // Config bit positions
   localparam int FCPG_CFG_CONT = 0;
   localparam int FCPG_CFG_DIR = 1;
   localparam int FCPG_CFG_FMT = 2;
   localparam int FCPG_CFG_LIMEN = 3;
   localparam int FCPG_CFG_LIMINV = 4;
   localparam int FCPG_CFG_W = 5;
   // Control bit positions
   localparam int FCPG_CTRL_START = 0;
   localparam int FCPG_CTRL_STOP = 1;
   // Status bits per channel: done at ch, abort at ch+4
   localparam int FCPG_ABORT_BASE = 4;
   // Widths
   localparam int FCPG_COUNT_W = 15;
   localparam int FCPG_RATE_W = 15;
   localparam int FCPG_ACC_W = 15;
   localparam int FCPG_WID_W = 15;
   localparam int FCPG_PH_W = 32;
   // Maximum count per train
   localparam logic [14:0] FCPG_COUNT_MAX = 15'h7_FFF;
   // Clock rate, and units: rate in 0.5 p/s, accel in 20 p/s/s, width in 100 us
   localparam longint FCPG_CLK_HZ = 200_000_000;
   localparam longint FCPG_RATE_UNITS_PER_HZ = 2;
   localparam longint FCPG_ACC_UNIT = 20;
   localparam longint FCPG_WIDTH_UNIT_US = 100;
   localparam longint FCPG_WIDTH_UNIT_CYC = FCPG_WIDTH_UNIT_US * FCPG_CLK_HZ / 1_000_000;
   // Ramp tick: rate is updated every tick, one tick per 1/40 s
   localparam longint FCPG_RAMP_HZ = FCPG_ACC_UNIT * FCPG_RATE_UNITS_PER_HZ;
   localparam longint FCPG_RAMP_CYC = FCPG_CLK_HZ / FCPG_RAMP_HZ;
   // Phase step per rate unit per cycle, scaled 2^32
   localparam longint FCPG_PH_DIV = FCPG_CLK_HZ * FCPG_RATE_UNITS_PER_HZ;
   // Channel state
   typedef enum logic [2:0]
   {
      FCPG_IDLE = 3'b001,
      FCPG_RUN = 3'b010,
      FCPG_DONE = 3'b100
   } fcpg_state_t;
   // Per-channel settings carried together
   typedef struct packed
   {
      logic [FCPG_COUNT_W-1:0] count;
      logic [FCPG_RATE_W-1:0] rstart;
      logic [FCPG_RATE_W-1:0] rfinal;
      logic [FCPG_ACC_W-1:0] accel;
      logic [FCPG_WID_W-1:0] width;
      logic [FCPG_CFG_W-1:0] cfg;
   } fcpg_chcfg_t;
endpackage

//--- rtl/fcpg_top.sv
// Four-channel programmable stepper pulse train generator with Avalon-MM slave.
// Assumes one 200 MHz clock; limit inputs arrive asynchronously from pins.
// What this block does
// - Four channels emit counted trains up to 32767
// - Start rate, accel, final rate, width per channel
// - Rates up to 16K p/s, 0.5 p/s steps
// - Acceleration about 655K, 20 p/s/s steps
// - Pulse width up to 3,276,700 microseconds
// - Ramp rate from start to final at accel
// - Enabled limit input aborts train that direction
// - Software inverts active sense of limits
// - Continuous mode ignores count, runs until stopped
// - Rate changes mid-train stay glitch free
// - Pulse/direction or CW/CCW output format selectable
// - Remaining pulse count readable at any time
// - Interrupt output enabled or disabled by software
`timescale 1ns/1ps
`default_nettype none
module fcpg_top
   import fcpg_pkg::*;
#(
   parameter int NCH = FCPG_NCH,
   parameter int RAMP_CYC = int'(FCPG_RAMP_CYC),
   parameter int WIDTH_UNIT_CYC = int'(FCPG_WIDTH_UNIT_CYC)
)
(
   // Clock, reset, enable
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic clk_en_in,
   // Avalon-MM slave
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Limit switch pins: one forward and one reverse bit per channel
   input wire logic [NCH-1:0] lim_fwd_in,
   input wire logic [NCH-1:0] lim_rev_in,
   // Pulse outputs: A is pulse or CW, B is direction or CCW
   output logic [NCH-1:0] out_a_out,
   output logic [NCH-1:0] out_b_out,
   // Interrupt
   output logic irq_out
);

   // Rate-to-phase-step conversion, shared by every channel
   function automatic logic [FCPG_PH_W-1:0] rate_step(input logic [FCPG_RATE_W:0] r);
      logic [63:0] p;
      p = (64'(r) << 32) / 64'(FCPG_PH_DIV);
      return p[FCPG_PH_W-1:0];
   endfunction

   // Bus write over one register's old value: each enabled lane takes the new byte
   function automatic logic [31:0] wm(input logic [31:0] old);
      logic [31:0] m;
      m = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}}, {8{avs_byteenable_in[1]}},
           {8{avs_byteenable_in[0]}}};
      return (avs_writedata_in & m) | (old & ~m);
   endfunction

   // Programmed settings and run state
   fcpg_chcfg_t cfg_reg [NCH];
   fcpg_state_t st_reg [NCH];
   logic [FCPG_COUNT_W-1:0] remain_reg [NCH]; // Pulses still outstanding
   logic [FCPG_RATE_W:0] rate_reg [NCH]; // Current ramped rate, 0.5 p/s units
   logic [FCPG_PH_W-1:0] phase_reg [NCH]; // Phase accumulator
   logic [31:0] wcnt_reg [NCH]; // Pulse high time counter
   logic [NCH-1:0] pulse_reg; // Pulse high
   logic [NCH-1:0] dir_reg; // Direction latched at start
   logic [NCH-1:0] fmt_reg; // Format latched at start
   logic [2*NCH-1:0] status_reg; // Done and abort sticky flags
   logic [2*NCH-1:0] mask_reg; // Interrupt mask
   logic ien_reg; // Global interrupt enable
   logic [31:0] ramp_cnt_reg; // Ramp tick divider
   logic ramp_tick;
   logic [NCH-1:0] start_req, stop_req, fin_ev, abort_ev;
   // Limit synchronisers, three stages each
   logic [NCH-1:0] lf_s1_reg, lf_s2_reg, lf_s3_reg, lf_reg;
   logic [NCH-1:0] lr_s1_reg, lr_s2_reg, lr_s3_reg, lr_reg;
   // Bus decode
   logic bus_wr, bus_rd, rd_pend_reg;
   logic [1:0] sel_ch;
   logic [4:0] sel_off;
   logic in_ch;

   assign in_ch = avs_address_in < 8'(NCH * FCPG_CH_STRIDE);
   assign sel_ch = avs_address_in[6:5];
   assign sel_off = avs_address_in[4:0];
   assign bus_wr = avs_write_in & clk_en_in;
   assign bus_rd = avs_read_in & clk_en_in;

   // Limit pins pass three flops; a change counts when stages two and three agree
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         {lf_s1_reg, lf_s2_reg, lf_s3_reg, lf_reg} <= '0;
         {lr_s1_reg, lr_s2_reg, lr_s3_reg, lr_reg} <= '0;
      end
      else if (clk_en_in)
      begin
         lf_s1_reg <= lim_fwd_in;
         lf_s2_reg <= lf_s1_reg;
         lf_s3_reg <= lf_s2_reg;
         lr_s1_reg <= lim_rev_in;
         lr_s2_reg <= lr_s1_reg;
         lr_s3_reg <= lr_s2_reg;
         // Stages agree: take the new level; they differ: hold the old one
         lf_reg <= (lf_s2_reg & lf_s3_reg) | (lf_reg & (lf_s2_reg | lf_s3_reg));
         lr_reg <= (lr_s2_reg & lr_s3_reg) | (lr_reg & (lr_s2_reg | lr_s3_reg));
      end
   end

   // Ramp tick: one rate step of one unit per tick gives 20 p/s/s per accel unit
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         ramp_cnt_reg <= '0;
      end
      else if (clk_en_in)
      begin
         ramp_cnt_reg <= (ramp_cnt_reg >= 32'(RAMP_CYC - 1)) ? '0 : ramp_cnt_reg + 32'd1;
      end
   end
   assign ramp_tick = ramp_cnt_reg == 32'(RAMP_CYC - 1);

   // Register writes: settings and strobes
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         for (int i = 0; i < NCH; i++)
         begin
            cfg_reg[i] <= '0;
         end
         mask_reg <= '0;
         ien_reg <= 1'b0;
      end
      else if (bus_wr && !avs_waitrequest_out)
      begin
         if (in_ch)
         begin
            // Final rate, accel and width may change while running; start rate waits for the next start
            case (sel_off)
               FCPG_OFF_COUNT: cfg_reg[sel_ch].count <= 15'(wm(32'(cfg_reg[sel_ch].count)));
               FCPG_OFF_RSTART: cfg_reg[sel_ch].rstart <= 15'(wm(32'(cfg_reg[sel_ch].rstart)));
               FCPG_OFF_RFINAL: cfg_reg[sel_ch].rfinal <= 15'(wm(32'(cfg_reg[sel_ch].rfinal)));
               FCPG_OFF_ACCEL: cfg_reg[sel_ch].accel <= 15'(wm(32'(cfg_reg[sel_ch].accel)));
               FCPG_OFF_WIDTH: cfg_reg[sel_ch].width <= 15'(wm(32'(cfg_reg[sel_ch].width)));
               FCPG_OFF_CFG: cfg_reg[sel_ch].cfg <= 5'(wm(32'(cfg_reg[sel_ch].cfg)));
               default:
               begin
               end
            endcase
         end
         else if (avs_address_in == FCPG_ADDR_MASK && avs_byteenable_in[0])
         begin
            mask_reg <= avs_writedata_in[2*NCH-1:0];
         end
         else if (avs_address_in == FCPG_ADDR_IEN && avs_byteenable_in[0])
         begin
            ien_reg <= avs_writedata_in[0];
         end
      end
   end

   // Start and stop strobes decoded from control writes
   always_comb
   begin
      start_req = '0;
      stop_req = '0;
      if (bus_wr && !avs_waitrequest_out && in_ch && sel_off == FCPG_OFF_CTRL &&
          avs_byteenable_in[0])
      begin
         start_req[sel_ch] = avs_writedata_in[FCPG_CTRL_START];
         stop_req[sel_ch] = avs_writedata_in[FCPG_CTRL_STOP];
      end
   end

   // Per-channel train engine
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         for (int i = 0; i < NCH; i++)
         begin
            st_reg[i] <= FCPG_IDLE;
            remain_reg[i] <= '0;
            rate_reg[i] <= '0;
            phase_reg[i] <= '0;
            wcnt_reg[i] <= '0;
         end
         {pulse_reg, dir_reg, fmt_reg, fin_ev, abort_ev} <= '0;
      end
      else if (clk_en_in)
      begin
         fin_ev <= '0;
         abort_ev <= '0;
         for (int i = 0; i < NCH; i++)
         begin
            logic lim_act;
            logic [FCPG_PH_W:0] ph_sum;
            lim_act = (dir_reg[i] ? lr_reg[i] : lf_reg[i]) ^
                      cfg_reg[i].cfg[FCPG_CFG_LIMINV];
            ph_sum = {1'b0, phase_reg[i]} + {1'b0, rate_step(rate_reg[i])};
            case (st_reg[i])
               FCPG_IDLE, FCPG_DONE:
               begin
                  pulse_reg[i] <= 1'b0;
                  if (start_req[i])
                  begin
                     st_reg[i] <= FCPG_RUN;
                     remain_reg[i] <= cfg_reg[i].count;
                     rate_reg[i] <= {1'b0, cfg_reg[i].rstart};
                     phase_reg[i] <= '0;
                     dir_reg[i] <= cfg_reg[i].cfg[FCPG_CFG_DIR];
                     fmt_reg[i] <= cfg_reg[i].cfg[FCPG_CFG_FMT];
                  end
               end
               FCPG_RUN:
               begin
                  // Rate ramps one step per tick; phase keeps running so no gap appears
                  if (ramp_tick)
                  begin
                     if (rate_reg[i] < {1'b0, cfg_reg[i].rfinal})
                     begin
                        rate_reg[i] <= (rate_reg[i] + 16'(cfg_reg[i].accel) >
                           {1'b0, cfg_reg[i].rfinal}) ? {1'b0, cfg_reg[i].rfinal} :
                           rate_reg[i] + 16'(cfg_reg[i].accel);
                     end
                     else if (rate_reg[i] > {1'b0, cfg_reg[i].rfinal})
                     begin
                        rate_reg[i] <= (rate_reg[i] < {1'b0, cfg_reg[i].rfinal} +
                           16'(cfg_reg[i].accel)) ? {1'b0, cfg_reg[i].rfinal} :
                           rate_reg[i] - 16'(cfg_reg[i].accel);
                     end
                  end
                  phase_reg[i] <= ph_sum[FCPG_PH_W-1:0];
                  // Pulse width counter ends the high phase
                  if (pulse_reg[i])
                  begin
                     if (wcnt_reg[i] == 32'd0)
                     begin
                        pulse_reg[i] <= 1'b0;
                     end
                     else
                     begin
                        wcnt_reg[i] <= wcnt_reg[i] - 32'd1;
                     end
                  end
                  if (stop_req[i])
                  begin
                     st_reg[i] <= FCPG_IDLE;
                     pulse_reg[i] <= 1'b0;
                  end
                  else if (cfg_reg[i].cfg[FCPG_CFG_LIMEN] && lim_act)
                  begin
                     st_reg[i] <= FCPG_DONE;
                     pulse_reg[i] <= 1'b0;
                     abort_ev[i] <= 1'b1;
                  end
                  else if (!cfg_reg[i].cfg[FCPG_CFG_CONT] && remain_reg[i] == '0 &&
                           !pulse_reg[i])
                  begin
                     st_reg[i] <= FCPG_DONE;
                     fin_ev[i] <= 1'b1;
                  end
                  else if (ph_sum[FCPG_PH_W] && !pulse_reg[i] &&
                           (cfg_reg[i].cfg[FCPG_CFG_CONT] || remain_reg[i] != '0))
                  begin
                     pulse_reg[i] <= 1'b1;
                     wcnt_reg[i] <= 32'(cfg_reg[i].width) * 32'(WIDTH_UNIT_CYC) -
                                    32'd1;
                     if (!cfg_reg[i].cfg[FCPG_CFG_CONT])
                     begin
                        remain_reg[i] <= remain_reg[i] - 15'd1;
                     end
                  end
               end
               default:
               begin
                  st_reg[i] <= FCPG_IDLE;
               end
            endcase
         end
      end
   end

   // Output format: pulse plus direction, or separate CW and CCW lines
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         out_a_out <= '0;
         out_b_out <= '0;
      end
      else if (clk_en_in)
      begin
         // CW/CCW: direction steers the pulse to one line; else line B carries direction
         out_a_out <= pulse_reg & ~(fmt_reg & dir_reg);
         out_b_out <= (fmt_reg & pulse_reg & dir_reg) | (~fmt_reg & dir_reg);
      end
   end

   // Sticky status: set wins over write-one-to-clear
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         status_reg <= '0;
      end
      else if (clk_en_in)
      begin
         logic [2*NCH-1:0] clr;
         clr = '0;
         if (bus_wr && !avs_waitrequest_out && avs_address_in == FCPG_ADDR_STATUS &&
             avs_byteenable_in[0])
         begin
            clr = avs_writedata_in[2*NCH-1:0];
         end
         status_reg <= (status_reg & ~clr) | {abort_ev, fin_ev};
      end
   end

   // Interrupt level, registered
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         irq_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         irq_out <= ien_reg && |(status_reg & mask_reg);
      end
   end

   // Bus answer: writes and reads each take one cycle of wait, read data registered with the answer
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out <= '0;
         rd_pend_reg <= 1'b0;
      end
      else if (clk_en_in)
      begin
         avs_waitrequest_out <= 1'b1;
         if ((bus_rd || bus_wr) && avs_waitrequest_out && !rd_pend_reg)
         begin
            avs_waitrequest_out <= 1'b0;
            rd_pend_reg <= bus_rd;
            avs_readdata_out <= '0;
            if (bus_rd && in_ch)
            begin
               case (sel_off)
                  FCPG_OFF_COUNT: avs_readdata_out <= 32'(cfg_reg[sel_ch].count);
                  FCPG_OFF_RSTART: avs_readdata_out <= 32'(cfg_reg[sel_ch].rstart);
                  FCPG_OFF_RFINAL: avs_readdata_out <= 32'(cfg_reg[sel_ch].rfinal);
                  FCPG_OFF_ACCEL: avs_readdata_out <= 32'(cfg_reg[sel_ch].accel);
                  FCPG_OFF_WIDTH: avs_readdata_out <= 32'(cfg_reg[sel_ch].width);
                  FCPG_OFF_CFG: avs_readdata_out <= 32'(cfg_reg[sel_ch].cfg);
                  FCPG_OFF_CTRL: avs_readdata_out <= 32'(st_reg[sel_ch]);
                  FCPG_OFF_REMAIN: avs_readdata_out <= 32'(remain_reg[sel_ch]);
                  default: avs_readdata_out <= '0;
               endcase
            end
            else if (bus_rd)
            begin
               case (avs_address_in)
                  FCPG_ADDR_STATUS: avs_readdata_out <= 32'(status_reg);
                  FCPG_ADDR_MASK: avs_readdata_out <= 32'(mask_reg);
                  FCPG_ADDR_IEN: avs_readdata_out <= 32'(ien_reg);
                  default: avs_readdata_out <= '0;
               endcase
            end
         end
         else
         begin
            rd_pend_reg <= 1'b0;
         end
      end
   end

endmodule // fcpg_top
`default_nettype wire

//--- verification/fcpg_checker.sv
// Bus and interrupt checker for the four-channel pulse generator.
// Assumes it is bound into fcpg_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module fcpg_checker
   import fcpg_pkg::*;
#(
   parameter int NCH = FCPG_NCH
)
(
   // Clock, reset, enable
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic clk_en_in,
   // Register bus
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   // Pins
   input wire logic [NCH-1:0] lim_fwd_in,
   input wire logic [NCH-1:0] lim_rev_in,
   input wire logic [NCH-1:0] out_a_out,
   input wire logic [NCH-1:0] out_b_out,
   input wire logic irq_out
);
   // Address that no register decodes
   localparam logic [7:0] HOLE = 8'h8C;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);
   // Accepted read of one address
   sequence s_rd(a);
      avs_read_in && !avs_waitrequest_out && avs_address_in == a;
   endsequence
   // Accepted write of a zero in lane bit 0
   sequence s_wr0(a);
      avs_write_in && !avs_waitrequest_out && avs_address_in == a && !avs_writedata_in[0];
   endsequence
   // Interrupt line drops within two cycles
   sequence s_irq_low;
      ##[1:2] !irq_out;
   endsequence
   AST_WR_ANSWER: assert property (avs_write_in && avs_waitrequest_out && !$past(avs_read_in)
      |=> !avs_waitrequest_out) else $error("write not answered next cycle");
   AST_RD_ANSWER: assert property (avs_read_in && avs_waitrequest_out
      |-> ##[1:2] !avs_waitrequest_out) else $error("read not answered");
   AST_ONE_CYCLE: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("waitrequest low too long");
   AST_NO_SPURIOUS: assert property (!avs_read_in && !avs_write_in && avs_waitrequest_out
      |=> avs_waitrequest_out) else $error("accept without request");
   AST_RDATA_HOLD: assert property (avs_waitrequest_out |-> $stable(avs_readdata_out))
      else $error("read data moved between accesses");
   AST_HOLE: assert property (s_rd(HOLE) |-> avs_readdata_out == 32'h0000_0000)
      else $error("unmapped read not zero");
   AST_STATUS_UPPER: assert property (s_rd(FCPG_ADDR_STATUS) |-> avs_readdata_out[31:8] == 0)
      else $error("status upper bits set");
   AST_REMAIN_RANGE: assert property (avs_read_in && !avs_waitrequest_out && !avs_address_in[7]
      && avs_address_in[4:0] == FCPG_OFF_REMAIN |-> avs_readdata_out[31:15] == 0)
      else $error("remaining count above 32767");
   AST_IEN_OFF: assert property (s_wr0(FCPG_ADDR_IEN) |-> s_irq_low)
      else $error("interrupt stays up after disable");
   AST_MASK_OFF: assert property (s_wr0(FCPG_ADDR_MASK) && avs_writedata_in[7:0] == 8'h00
      |-> s_irq_low) else $error("interrupt stays up after masking");
endmodule // fcpg_checker
bind fcpg_top fcpg_checker #(.NCH(NCH)) fcpg_checker_inst (.*);
`default_nettype wire

//--- verification/fcpg_motor_model.sv
// Stepper translator model: counts CW and CCW steps, measures pulse width.
// Assumes the bench tells it each channel's output format and switch sense.
`timescale 1ns/1ps
`default_nettype none
module fcpg_motor_model
   import fcpg_pkg::*;
#(
   parameter int NCH = FCPG_NCH
)
(
   // Clock and pulse lines
   input wire logic ref_clk_in,
   input wire logic [NCH-1:0] out_a_in,
   input wire logic [NCH-1:0] out_b_in,
   // Wiring choices from the bench
   input wire logic [NCH-1:0] fmt_in,
   input wire logic [NCH-1:0] inv_in,
   input wire logic [NCH-1:0] fwd_hit_in,
   input wire logic [NCH-1:0] rev_hit_in,
   // Limit switch pins toward the device
   output logic [NCH-1:0] lim_fwd_out,
   output logic [NCH-1:0] lim_rev_out
);
   int cw_cnt[NCH]; // Steps taken clockwise
   int ccw_cnt[NCH]; // Steps taken counter-clockwise
   int hi_len[NCH]; // Length of the last pulse on line A
   int run_len[NCH]; // Cycles line A has been high
   logic [NCH-1:0] a_q = '0;
   logic [NCH-1:0] b_q = '0;
   // Switch wired so that a hit shows the level the chosen sense treats as active
   assign lim_fwd_out = fwd_hit_in ^ inv_in;
   assign lim_rev_out = rev_hit_in ^ inv_in;
   // Steps on rising edges; the direction line is read as it stands
   always @(posedge ref_clk_in)
   begin
      for (int i = 0; i < NCH; i++)
      begin
         if (out_a_in[i] && !a_q[i] && (fmt_in[i] || !out_b_in[i]))
            cw_cnt[i]++;
         if (out_a_in[i] && !a_q[i] && !fmt_in[i] && out_b_in[i])
            ccw_cnt[i]++;
         if (fmt_in[i] && out_b_in[i] && !b_q[i])
            ccw_cnt[i]++;
         if (out_a_in[i])
            run_len[i]++;
         else
         begin
            // Width is taken only at the falling edge, so a stuck line keeps the last width taken (0 if none)
            if (a_q[i])
               hi_len[i] = run_len[i];
            run_len[i] = 0;
         end
      end
      a_q <= out_a_in;
      b_q <= out_b_in;
   end
endmodule // fcpg_motor_model
`default_nettype wire

//--- verification/fcpg_top_bench.sv
// Self-checking bench for the four-channel pulse generator.
// Assumes shortened ramp and width units so a train fits in the run.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin mismatches++; \
   $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module fcpg_top_bench;
   import fcpg_pkg::*;
   localparam int WCYC = 4; // Cycles per width unit in this run
   logic ref_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [7:0] addr = '0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = '0;
   logic [3:0] fmt = '0;
   logic [3:0] inv = '0;
   logic [3:0] fhit = '0;
   logic [3:0] rhit = '0;
   wire logic [3:0] lim_f;
   wire logic [3:0] lim_r;
   wire logic [3:0] oa;
   wire logic [3:0] ob;
   wire logic [31:0] rdata;
   wire logic wreq;
   wire logic irq;
   int mismatches = 0;
   int n_tests = 0;
   always #2.5 ref_clk_in = ~ref_clk_in;
   fcpg_top #(.RAMP_CYC(100), .WIDTH_UNIT_CYC(WCYC)) fcpg_top_inst (.ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in), .clk_en_in(1'b1), .avs_address_in(addr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .lim_fwd_in(lim_f),
      .lim_rev_in(lim_r), .out_a_out(oa), .out_b_out(ob), .irq_out(irq));
   fcpg_motor_model #(.NCH(4)) fcpg_motor_model_inst (.ref_clk_in(ref_clk_in), .out_a_in(oa),
      .out_b_in(ob), .fmt_in(fmt), .inv_in(inv), .fwd_hit_in(fhit), .rev_hit_in(rhit),
      .lim_fwd_out(lim_f), .lim_rev_out(lim_r));
   // Channel register address
   function automatic logic [7:0] ca(input logic [1:0] n, input logic [4:0] off);
      return {1'b0, n, off};
   endfunction
   // One bus access: held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int t;
      t = 0;
      @(posedge ref_clk_in);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= d;
      @(posedge ref_clk_in);
      while (wreq !== 1'b0 && t < 50)
      begin
         t++;
         @(posedge ref_clk_in);
      end
      `CHK("bus answer", 1'b0, wreq)
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   // Read and compare
   task automatic rchk(input logic [7:0] a, input logic [31:0] ex, input string nm);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      `CHK(nm, ex, q)
   endtask
   // Poll status until a bit sets, bounded
   task automatic wait_stat(input int b, input int lim);
      logic [31:0] q;
      int t;
      q = '0;
      t = 0;
      while (q[b] !== 1'b1 && t < lim)
      begin
         bus(1'b0, FCPG_ADDR_STATUS, 32'h0000_0000, q);
         t++;
      end
      `CHK("status bit", 1'b1, q[b])
   endtask
   // Program a channel at top rate, one width unit, then start it
   task automatic setup(input logic [1:0] n, input logic [14:0] cnt, input logic [4:0] cfg);
      wreg(ca(n, FCPG_OFF_COUNT), {17'h0, cnt});
      wreg(ca(n, FCPG_OFF_RSTART), 32'h0000_7FFF);
      wreg(ca(n, FCPG_OFF_RFINAL), 32'h0000_7FFF);
      wreg(ca(n, FCPG_OFF_ACCEL), 32'h0000_0000);
      wreg(ca(n, FCPG_OFF_WIDTH), 32'h0000_0001);
      wreg(ca(n, FCPG_OFF_CFG), {27'h0, cfg});
      wreg(ca(n, FCPG_OFF_CTRL), 32'h0000_0001);
   endtask
   // Idle state after reset, and an unmapped place
   task automatic t_reset();
      `CHK("waitrequest", 1'b1, wreq)
      `CHK("irq", 1'b0, irq)
      `CHK("out a", 4'h0, oa)
      rchk(FCPG_ADDR_STATUS, 32'h0000_0000, "status");
      rchk(FCPG_ADDR_IEN, 32'h0000_0000, "ien");
      rchk(ca(0, FCPG_OFF_CTRL), 32'h0000_0001, "idle");
      wreg(8'h8C, 32'hFFFF_FFFF);
      rchk(8'h8C, 32'h0000_0000, "hole");
   endtask
   // Counted train, completion flag and interrupt gating
   task automatic t_counted();
      wreg(FCPG_ADDR_MASK, 32'h0000_0001);
      wreg(FCPG_ADDR_IEN, 32'h0000_0001);
      setup(2'd0, 15'h0002, 5'h00);
      rchk(ca(0, FCPG_OFF_REMAIN), 32'h0000_0002, "remain");
      rchk(ca(0, FCPG_OFF_CTRL), 32'h0000_0002, "run");
      wait_stat(0, 10000);
      repeat (8) @(posedge ref_clk_in);
      `CHK("cw steps", 2, fcpg_motor_model_inst.cw_cnt[0])
      `CHK("ccw steps", 0, fcpg_motor_model_inst.ccw_cnt[0])
      `CHK("width", WCYC, fcpg_motor_model_inst.hi_len[0])
      `CHK("dir line", 1'b0, ob[0])
      `CHK("irq done", 1'b1, irq)
      rchk(ca(0, FCPG_OFF_REMAIN), 32'h0000_0000, "remain end");
      rchk(ca(0, FCPG_OFF_CTRL), 32'h0000_0004, "done");
      wreg(FCPG_ADDR_IEN, 32'h0000_0000);
      repeat (3) @(posedge ref_clk_in);
      `CHK("irq off", 1'b0, irq)
      wreg(FCPG_ADDR_IEN, 32'h0000_0001);
      repeat (3) @(posedge ref_clk_in);
      `CHK("irq on", 1'b1, irq)
      wreg(FCPG_ADDR_MASK, 32'h0000_0000);
      repeat (3) @(posedge ref_clk_in);
      `CHK("irq masked", 1'b0, irq)
      wreg(FCPG_ADDR_STATUS, 32'h0000_0001);
      rchk(FCPG_ADDR_STATUS, 32'h0000_0000, "status clear");
   endtask
   // Continuous reverse train on CW/CCW lines; inverted limits, wrong side first
   task automatic t_limit();
      @(posedge ref_clk_in);
      inv <= 4'b0010;
      fmt <= 4'b0010;
      setup(2'd1, 15'h0001, 5'h1F);
      fhit <= 4'b0010;
      repeat (26000) @(posedge ref_clk_in);
      `CHK("past count", 1'b1, fcpg_motor_model_inst.ccw_cnt[1] >= 2)
      `CHK("cw line", 0, fcpg_motor_model_inst.cw_cnt[1])
      rchk(FCPG_ADDR_STATUS, 32'h0000_0000, "no abort");
      rhit <= 4'b0010;
      wait_stat(FCPG_ABORT_BASE + 1, 5000);
   endtask
   // Verdict and end of run
   task automatic report_and_stop();
      if (mismatches == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      repeat (16) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      t_reset();
      t_counted();
      t_limit();
      report_and_stop();
   end
   // Watchdog sized above the two long trains
   initial
   begin
      repeat (90000) @(posedge ref_clk_in);
      mismatches++;
      report_and_stop();
   end
endmodule // fcpg_top_bench
`default_nettype wire
